// file: asl_pkg.sv
// Purpose: shared constants of the acquisition sync loop
// Assumes: 16-bit register port, byte offsets
// Notes:   writable register reset values are zero; status resets with done set
package asl_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] SETUP_OFS   = 8'h06;
  localparam logic [7:0] OFFSET_OFS  = 8'h08;
  localparam logic [7:0] LOOP_OFS    = 8'h0a;
  localparam logic [7:0] FORMAT_OFS  = 8'h0c;
  localparam logic [7:0] PRETRIG_OFS = 8'h0e;
  localparam logic [7:0] BLOCK_OFS   = 8'h10;
  // ==========================================
  // field positions
  localparam int PULL_BIT   = 2;
  localparam int DIS_BIT    = 3;
  localparam int COUPLE_BIT = 4;
  localparam int FILT_BIT   = 5;
  localparam int FLOAT_BIT  = 6;
  localparam int INSEL_BIT  = 7;
  localparam int BLKM_BIT   = 0;
  localparam int ARMED_BIT  = 10;
  localparam int DONE_BIT   = 11;
  localparam logic [15:0] REG_RST = 16'h0000;
  // ==========================================
  // loop commands
  localparam logic [1:0] OPC_DSPRST = 2'h0;
  localparam logic [1:0] OPC_LOAD   = 2'h1;
  localparam logic [1:0] OPC_RUN    = 2'h2;
  localparam logic [1:0] OPC_GO     = 2'h3;
  // sample scale 0.4334 in signed q16
  localparam logic signed [16:0] SCALE_Q16 = 17'sh06ef4;
  localparam int FIFO_W = 16;
  localparam int FIFO_D = 16;
  // loop states in status code order
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_MEAS, ST_TRIG} asl_state_t;
endpackage : asl_pkg

// file: asl_fifo.sv
// Purpose: sample buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   push and pop may share a cycle
`timescale 1ns/1ns
module asl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   flush,
  input  wire logic [WIDTH-1:0]       inData,
  input  wire logic                   inValid,
  output logic                        inReady,
  output logic [WIDTH-1:0]            outData,
  output logic                        outValid,
  input  wire logic                   outReady,
  output logic [$clog2(DEPTH):0]      count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];     // storage
  logic [AW-1:0]    wrPtr_r;         // write index
  logic [AW-1:0]    rdPtr_r;         // read index
  logic [AW:0]      cnt_r;           // fill level
  logic             push;            // accepted write
  logic             pop;             // accepted read
  assign inReady  = (cnt_r != DEPTH[AW:0]) || outReady;
  assign outValid = (cnt_r != '0);
  assign outData  = mem[rdPtr_r];
  assign count    = cnt_r;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
  // pointers and level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r   <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r   <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + AW'(push);
      rdPtr_r <= rdPtr_r + AW'(pop);
      cnt_r   <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : asl_fifo

// file: asl_sync_loop.sv
// Purpose: front-end setup and SYNC driven measurement loop
// Assumes: adcValid is a one-cycle sample strobe on clk
// Notes:   SYNC is wired-AND; syncOeN low pulls it low
`timescale 1ns/1ns
module asl_sync_loop (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        wrEn,
  input  wire logic [7:0]  wrAddr,
  input  wire logic [15:0] wrData,
  input  wire logic        rdEn,
  input  wire logic [7:0]  rdAddr,
  output logic [15:0]      rdData,
  input  wire logic [15:0] adcData,
  input  wire logic        adcValid,
  input  wire logic        syncIn,
  output logic             syncOut,
  output logic             syncOeN,
  output logic             gainInv,
  output logic             att24,
  output logic             att12,
  output logic             att6,
  output logic             couplingSelect,
  output logic             filterBypass,
  output logic             shieldGround,
  output logic             inputConnector,
  output logic [11:0]      offsetCode,
  output logic [15:0]      mixData,
  output logic             mixValid,
  output logic             dspReset,
  output logic             dspLoad,
  output logic [15:0]      outData,
  output logic             outValid,
  input  wire logic        outReady,
  output logic [1:0]       loopState,
  output logic             armed,
  output logic             measDone
);
  import asl_pkg::*;

  // ==========================================
  // registers
  logic [15:0] setup_r;           // front-end setup
  logic [15:0] offset_r;          // offset code
  logic [1:0]  opc_r;             // loop command
  logic        pull_r;            // software pull
  logic        dis_r;             // converter disable
  logic        blkMode_r;         // block mode
  logic [3:0]  pretrig_r;         // pre-trigger depth
  logic [15:0] blockLen_r;        // post-trigger length
  asl_state_t  st_r;              // loop state
  logic        sync1_r;           // synchroniser stage 1
  logic        sync2_r;           // synchroniser stage 2
  logic        syncD_r;           // delayed copy
  logic        fallPend_r;        // falling edge waiting
  logic        risePend_r;        // rising edge waiting
  logic        flush_r;           // fifo flush pulse
  logic        collect_r;         // measure collecting
  logic [15:0] postCnt_r;         // measure sample count
  logic signed [32:0] prod;       // scaler product
  logic [15:0] scaled;            // scaled sample
  logic        fall;              // falling sync edge
  logic        rise;              // rising sync edge
  logic        preMet;            // pre-trigger filled
  logic        sampleWr;          // sample enters fifo
  logic        fifoInRdy;         // fifo accepts
  logic        fifoOutVld;        // fifo holds data
  logic        fifoPop;           // fifo read strobe
  logic        discard;           // drop oldest sample
  logic        portEn;            // port may drain
  logic        stopNow;           // collection ends
  logic        blockEnd;          // block length reached
  logic        holdLow;           // internal sync hold
  logic [4:0]  fifoCnt;           // fifo level

  // ==========================================
  // register writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      setup_r    <= REG_RST;
      offset_r   <= REG_RST;
      opc_r      <= REG_RST[1:0];
      pull_r     <= 1'b0;
      dis_r      <= 1'b0;
      blkMode_r  <= 1'b0;
      pretrig_r  <= REG_RST[3:0];
      blockLen_r <= REG_RST;
    end else if (wrEn) begin
      // address decode of writes
      if (wrAddr == SETUP_OFS) begin
        setup_r <= {8'h00, wrData[7:0]};
      end else if (wrAddr == OFFSET_OFS) begin
        offset_r <= {4'h0, wrData[11:0]};
      end else if (wrAddr == LOOP_OFS) begin
        opc_r  <= wrData[1:0];
        pull_r <= wrData[PULL_BIT];
        dis_r  <= wrData[DIS_BIT];
      end else if (wrAddr == FORMAT_OFS) begin
        blkMode_r <= wrData[BLKM_BIT];
      end else if (wrAddr == PRETRIG_OFS) begin
        pretrig_r <= wrData[3:0];
      end else if (wrAddr == BLOCK_OFS) begin
        blockLen_r <= wrData;
      end
    end else if (opc_r == OPC_GO) begin
      // loop forced idle this cycle, run next
      opc_r <= OPC_RUN;
    end
  end

  // ==========================================
  // register reads, registered answer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdData <= REG_RST;
    end else if (rdEn) begin
      if (rdAddr == STATUS_OFS) begin
        rdData <= {4'h0, measDone, armed, 8'h00, st_r};
      end else if (rdAddr == SETUP_OFS) begin
        rdData <= setup_r;
      end else if (rdAddr == OFFSET_OFS) begin
        rdData <= offset_r;
      end else begin
        // write-only or unmapped reads as zero
        rdData <= REG_RST;
      end
    end
  end

  // ==========================================
  // front-end drive, one stage per range bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gainInv        <= 1'b0;
      att24          <= 1'b0;
      att12          <= 1'b0;
      att6           <= 1'b0;
      couplingSelect <= 1'b0;
      filterBypass   <= 1'b0;
      shieldGround   <= 1'b0;
      inputConnector <= 1'b0;
      offsetCode     <= 12'h000;
    end else begin
      gainInv        <= setup_r[3];
      att24          <= setup_r[2];
      att12          <= setup_r[1];
      att6           <= setup_r[0];
      couplingSelect <= setup_r[COUPLE_BIT];
      filterBypass   <= setup_r[FILT_BIT];
      shieldGround   <= setup_r[FLOAT_BIT];
      inputConnector <= setup_r[INSEL_BIT];
      offsetCode     <= offset_r[11:0];
    end
  end

  // ==========================================
  // sample scaler, floor of q16 product
  assign prod   = $signed(adcData) * SCALE_Q16;
  assign scaled = prod[31:16];

  // mixer feed, blocked while disabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mixData  <= 16'h0000;
      mixValid <= 1'b0;
    end else begin
      mixData  <= scaled;
      mixValid <= adcValid && !dis_r;
    end
  end

  // ==========================================
  // sync input: two flops then edge detect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      syncD_r <= 1'b1;
    end else begin
      sync1_r <= syncIn;
      sync2_r <= sync1_r;
      syncD_r <= sync2_r;
    end
  end
  assign fall = syncD_r && !sync2_r;
  assign rise = !syncD_r && sync2_r;

  // edges wait for the next sample strobe; a new edge wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fallPend_r <= 1'b0;
      risePend_r <= 1'b0;
    end else begin
      fallPend_r <= fall || (fallPend_r && !adcValid);
      risePend_r <= rise || (risePend_r && !adcValid);
    end
  end

  // ==========================================
  // dsp strobes in the idle commands
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dspReset <= 1'b0;
      dspLoad  <= 1'b0;
    end else begin
      dspReset <= adcValid && fallPend_r && (opc_r == OPC_DSPRST);
      dspLoad  <= adcValid && fallPend_r && (opc_r == OPC_LOAD);
    end
  end

  // ==========================================
  // measurement loop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
    end else if (opc_r != OPC_RUN) begin
      // any other command holds idle
      st_r <= ST_IDLE;
    end else if (adcValid) begin
      case (st_r)
        ST_IDLE: begin
          if (fallPend_r) begin
            st_r <= ST_ARM;
          end
        end
        ST_ARM: begin
          if (risePend_r) begin
            st_r <= ST_TRIG;
          end
        end
        ST_TRIG: begin
          if (fallPend_r) begin
            st_r <= ST_MEAS;
          end
        end
        ST_MEAS: begin
          if (risePend_r) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // flush old data on entry to arm
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flush_r <= 1'b0;
    end else begin
      flush_r <= (opc_r == OPC_RUN) && adcValid
                 && (st_r == ST_IDLE) && fallPend_r;
    end
  end

  // ==========================================
  // fifo feed and drain
  // stale data still counted in the flush cycle must not release the line
  assign preMet   = !flush_r && (fifoCnt >= {1'b0, pretrig_r});
  // block mode: no post-trigger sample beyond the block length
  assign blockEnd = blkMode_r && (postCnt_r == blockLen_r);
  // no writes in idle or after collection ends
  assign sampleWr = adcValid && !flush_r && ((st_r == ST_ARM)
                    || (st_r == ST_TRIG)
                    || ((st_r == ST_MEAS) && collect_r && !blockEnd));
  // trim to the pre-trigger window, then drop the oldest per new sample
  assign discard  = (st_r == ST_TRIG) && fifoOutVld
                    && ((fifoCnt > {1'b0, pretrig_r}) || (sampleWr && preMet));
  // idle leftovers and measure data go to the port
  assign portEn   = (st_r == ST_IDLE) || (st_r == ST_MEAS);
  assign fifoPop  = discard || (portEn && outReady);
  assign outValid = portEn && fifoOutVld;
  // a full fifo that cannot take a sample is overflow
  assign stopNow  = collect_r && ((sampleWr && !fifoInRdy)
                    || blockEnd);

  asl_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .flush    (flush_r),
    .inData   (scaled),
    .inValid  (sampleWr),
    .inReady  (fifoInRdy),
    .outData  (outData),
    .outValid (fifoOutVld),
    .outReady (fifoPop),
    .count    (fifoCnt)
  );

  // collection window inside measure
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      collect_r <= 1'b0;
      postCnt_r <= 16'h0000;
    end else if (st_r != ST_MEAS) begin
      // armed again each time measure is entered
      collect_r <= 1'b1;
      postCnt_r <= 16'h0000;
    end else if (stopNow) begin
      collect_r <= 1'b0;
    end else if (sampleWr) begin
      postCnt_r <= postCnt_r + 16'h0001;
    end
  end

  // ==========================================
  // sync drive: hold low while filling or collecting
  assign holdLow = ((st_r == ST_ARM) && !preMet)
                   || ((st_r == ST_MEAS) && collect_r);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncOut <= 1'b0;
      syncOeN <= 1'b1;
    end else begin
      syncOut <= 1'b0;
      syncOeN <= !(pull_r || holdLow);
    end
  end

  // ==========================================
  // status outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loopState <= 2'h0;
      armed     <= 1'b0;
      measDone  <= 1'b1;
    end else begin
      loopState <= st_r;
      armed     <= (st_r == ST_TRIG)
                   || ((st_r == ST_ARM) && preMet);
      measDone  <= (st_r == ST_IDLE)
                   || ((st_r == ST_MEAS) && !collect_r);
    end
  end

endmodule : asl_sync_loop

// file: asl_sync_loop_properties.sv
// Purpose: port-level checks of the sync loop
// Assumes: one clock domain, clk
// Notes:   bound onto every asl_sync_loop
`timescale 1ns/1ns
module asl_sync_loop_chk
  import asl_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        wrEn,
  input wire logic [7:0]  wrAddr,
  input wire logic [15:0] wrData,
  input wire logic        rdEn,
  input wire logic [7:0]  rdAddr,
  input wire logic [15:0] rdData,
  input wire logic [15:0] adcData,
  input wire logic        adcValid,
  input wire logic        syncOut,
  input wire logic        syncOeN,
  input wire logic        gainInv,
  input wire logic        att24,
  input wire logic        att12,
  input wire logic        att6,
  input wire logic        couplingSelect,
  input wire logic        filterBypass,
  input wire logic        shieldGround,
  input wire logic        inputConnector,
  input wire logic [11:0] offsetCode,
  input wire logic [15:0] mixData,
  input wire logic        mixValid,
  input wire logic        outValid,
  input wire logic [1:0]  loopState,
  input wire logic        armed,
  input wire logic        measDone
);
  // ==========
  // helper mirrors
  logic               disR;  // disable bit as last written
  logic signed [31:0] prod;  // sample times q16 scale
  logic               setWr; // setup register write
  logic               offWr; // offset register write
  assign prod  = $signed(adcData) * SCALE_Q16;
  assign setWr = wrEn && wrAddr == SETUP_OFS;
  assign offWr = wrEn && wrAddr == OFFSET_OFS;
  // follow loop register writes for the disable bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) disR <= 1'b0;
    else if (wrEn && wrAddr == LOOP_OFS) disR <= wrData[DIS_BIT];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========
  // assertions
  setup_follow_a: assert property (setWr ##1 !setWr |-> ##1
    {inputConnector, shieldGround, filterBypass, couplingSelect, gainInv, att24, att12, att6} == $past(wrData[7:0], 2))
    else $error("front-end outputs differ from setup write");
  offset_follow_a: assert property (offWr ##1 !offWr |-> ##1 offsetCode == $past(wrData[11:0], 2))
    else $error("offset code differs from offset write");
  mix_scale_a: assert property (adcValid && !disR |=> mixValid && mixData == $past(prod[31:16]))
    else $error("scaled sample missing or wrong");
  mix_block_a: assert property (!(adcValid && !disR) |=> !mixValid)
    else $error("sample reached mixer while blocked");
  pull_low_a: assert property (wrEn && wrAddr == LOOP_OFS && wrData[PULL_BIT] |-> ##[1:2] !syncOeN)
    else $error("pull bit did not pull the line");
  sync_zero_a: assert property (syncOut == 1'b0)
    else $error("line driven high");
  port_gate_a: assert property (outValid |=> loopState == ST_IDLE || loopState == ST_MEAS)
    else $error("data offered outside idle or measure");
  loop_order_a: assert property ($changed(loopState) |-> loopState == ST_IDLE
    || loopState == {$past(loopState[0]), ~$past(loopState[1])})
    else $error("illegal loop state step");
  idle_done_a: assert property (loopState == ST_IDLE && $past(loopState) == ST_IDLE |-> measDone)
    else $error("done flag low in idle");
  trig_armed_a: assert property (loopState == ST_TRIG && $past(loopState) == ST_TRIG |-> armed)
    else $error("armed flag low in trigger");
  wo_read_a: assert property (rdEn && (rdAddr == LOOP_OFS || rdAddr == FORMAT_OFS) |=> rdData == 16'h0000)
    else $error("write-only register read nonzero");
  // main scenarios reached
  meas_c: cover property (loopState == ST_MEAS);
  trig_c: cover property (loopState == ST_TRIG && armed);
  drain_c: cover property (outValid && loopState == ST_IDLE);
endmodule : asl_sync_loop_chk

bind asl_sync_loop asl_sync_loop_chk u_chk (
  .clk, .resetn, .wrEn, .wrAddr, .wrData, .rdEn, .rdAddr, .rdData, .adcData, .adcValid,
  .syncOut, .syncOeN, .gainInv, .att24, .att12, .att6, .couplingSelect, .filterBypass,
  .shieldGround, .inputConnector, .offsetCode, .mixData, .mixValid, .outValid, .loopState,
  .armed, .measDone
);

// file: asl_sync_peer.sv
// Purpose: peer module and pull-up on the shared line
// Assumes: trigReq is a one-cycle request
// Notes:   line is wired-AND, high when all release
`timescale 1ns/1ns
module asl_sync_peer #(
  // cycles the peer pulls low; must outlast the device's edge latency
  // so that the device takes over the line without a high glitch
  parameter logic [3:0] HOLD = 4'hc
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic trigReq,
  input  wire logic devOeN,
  output logic      syncLine
);
  logic [3:0] holdR;  // remaining pull cycles of the peer
  // a triggering peer pulls the line for HOLD cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) holdR <= 4'h0;
    else if (trigReq) holdR <= HOLD;
    else if (holdR != 4'h0) holdR <= holdR - 4'h1;
  end
  // pull-up wins only when nobody pulls
  assign syncLine = devOeN & (holdR == 4'h0);
endmodule : asl_sync_peer

// file: asl_tb.sv
// Purpose: self-checking bench of the sync loop
// Assumes: inputs change 2 ns after rising edge
// Notes:   sample strobe every fourth cycle
`timescale 1ns/1ns
module tb;
  import asl_pkg::*;
  logic        clk = 0, resetn = 0, wrEn = 0, rdEn = 0, adcValid = 0;
  logic        outReady = 0, trigReq = 0, adcRun = 0, syncLine;
  logic [7:0]  wrAddr = 0, rdAddr = 0;
  logic [15:0] wrData = 0, adcData = 0, rdData, mixData, outData;
  logic [11:0] offsetCode;
  logic [1:0]  loopState;
  logic        syncOut, syncOeN, gainInv, att24, att12, att6, couplingSelect, filterBypass;
  logic        shieldGround, inputConnector, mixValid, dspReset, dspLoad, outValid, armed, measDone;
  int          mismatches = 0, compares = 0, cycles = 0, tick = 0;
  asl_sync_loop u_dut (.clk, .resetn, .wrEn, .wrAddr, .wrData, .rdEn, .rdAddr, .rdData, .adcData,
    .adcValid, .syncIn(syncLine), .syncOut, .syncOeN, .gainInv, .att24, .att12, .att6, .couplingSelect,
    .filterBypass, .shieldGround, .inputConnector, .offsetCode, .mixData, .mixValid, .dspReset,
    .dspLoad, .outData, .outValid, .outReady, .loopState, .armed, .measDone);
  asl_sync_peer u_peer (.clk, .resetn, .trigReq, .devOeN(syncOeN), .syncLine);
  always #10 clk = ~clk;
  // free-running sample strobe with counting data
  always @(posedge clk) begin
    #2 tick = tick + 1;
    if (adcRun) begin
      adcValid = (tick % 4 == 0);
      if (adcValid) adcData = adcData + 16'h0001;
    end
  end
  // hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  // ==========
  // shared tasks
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk); #2 wrEn = 1; wrAddr = a; wrData = d;
    @(posedge clk); #2 wrEn = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk); #2 rdEn = 1; rdAddr = a;
    @(posedge clk); #2 rdEn = 0;
    chk("rdData", exp, rdData);
  endtask : rd
  task automatic pulsePeer;
    @(posedge clk); #2 trigReq = 1;
    @(posedge clk); #2 trigReq = 0;
  endtask : pulsePeer
  task automatic waitSt(input logic [1:0] s);
    int n;
    n = 0;
    while (loopState !== s && n < 300) begin
      @(posedge clk); #2 n++;
    end
    chk("loopState", s, loopState);
  endtask : waitSt
  task automatic drain(input int n);
    int got;
    logic [15:0] prev;
    got = 0;
    prev = 16'h0000;
    outReady = 1;
    // scale below one on counting samples: words step by zero or one
    while (outValid === 1'b1 && got < 40) begin
      if (got > 0) chk("outStep", 16'h0001, {15'h0000, 16'(outData - prev) <= 16'h0001});
      prev = outData;
      @(posedge clk); #2 got++;
    end
    outReady = 0;
    chk("drainCount", 1, got >= n && got <= n + 2);
  endtask : drain
  // go command, peer fall to arm, release to trigger
  task automatic arm(input logic [15:0] fmt, input logic [15:0] pre);
    wr(FORMAT_OFS, fmt); wr(PRETRIG_OFS, pre); wr(BLOCK_OFS, 16'h0006);
    wr(LOOP_OFS, 16'h0003);
    repeat (20) @(posedge clk);
    #2 chk("goIdle", ST_IDLE, loopState);
    pulsePeer;
    waitSt(ST_ARM);
    chk("armHold", 0, syncOeN);
    waitSt(ST_TRIG);
    @(posedge clk); #2 chk("armed", 1, armed);
    rd(STATUS_OFS, 16'h0403);
  endtask : arm
  // ==========
  // scenarios
  task automatic t_regs;
    rd(STATUS_OFS, 16'h0800);
    rd(OFFSET_OFS, REG_RST);
    for (int i = 0; i < 8; i++) begin
      wr(SETUP_OFS, 16'h0001 << i);
      @(posedge clk); #2 chk("frontEnd", 16'h0001 << i, {inputConnector, shieldGround, filterBypass,
        couplingSelect, gainInv, att24, att12, att6});
      rd(SETUP_OFS, 16'h0001 << i);
    end
    wr(OFFSET_OFS, 16'hfabc);
    rd(OFFSET_OFS, 16'h0abc);
    chk("offsetCode", 16'h0abc, offsetCode);
    rd(8'h20, 16'h0000);
    rd(LOOP_OFS, 16'h0000);
  endtask : t_regs
  task automatic t_mix;
    logic [15:0] inV [4] = '{16'h7fff, 16'h8000, 16'h4000, 16'h0000};
    logic [15:0] outV [4] = '{16'h3779, 16'hc886, 16'h1bbd, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wr(LOOP_OFS, 16'h0008);
      @(posedge clk); #2 adcData = inV[i % 4]; adcValid = 1;
      @(posedge clk); #2 adcValid = 0;
      chk("mixValid", i < 4, mixValid);
      if (i < 4) chk("mixData", outV[i], mixData);
    end
    wr(LOOP_OFS, 16'h0000);
  endtask : t_mix
  task automatic t_dsp;
    logic seen;
    for (int c = 0; c < 2; c++) begin
      wr(LOOP_OFS, c[15:0]);
      pulsePeer;
      seen = 0;
      repeat (30) begin
        @(posedge clk); #2 seen = seen | (c == 0 ? dspReset : dspLoad);
      end
      chk("dspPulse", 1, seen);
      chk("cmdIdle", ST_IDLE, loopState);
    end
  endtask : t_dsp
  task automatic t_block;
    arm(16'h0001, 16'h0004);
    wr(LOOP_OFS, 16'h0006);
    waitSt(ST_MEAS);
    wr(LOOP_OFS, 16'h0002);
    @(posedge clk); #2 chk("measHold", 0, syncOeN);
    waitSt(ST_IDLE);
    chk("measDone", 1, measDone);
    drain(10);
  endtask : t_block
  task automatic t_cont;
    arm(16'h0000, 16'h0002);
    wr(LOOP_OFS, 16'h0006);
    waitSt(ST_MEAS);
    wr(LOOP_OFS, 16'h0002);
    waitSt(ST_IDLE);
    drain(16);
  endtask : t_cont
  task automatic t_force;
    arm(16'h0001, 16'h0002);
    wr(LOOP_OFS, 16'h0000);
    repeat (3) @(posedge clk);
    #2 chk("forcedIdle", ST_IDLE, loopState);
    drain(2);
  endtask : t_force
  task automatic tally_and_finish;
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (10) @(posedge clk);
    #2 resetn = 1;
    t_regs; t_mix;
    adcRun = 1;
    t_dsp; t_block; t_cont; t_force;
    tally_and_finish;
  end
endmodule : tb
